// ### hw/acs_sequencer.sv
// Successive-approximation converter sequencer with its register port.
`timescale 1ns/1ps
`include "acs_map.svh"

module acs_sequencer
  import acs_pkg::*;
#(
  parameter int RES_W = 10,
  parameter int CH_W  = 5
) (
  input  wire logic                   clock_i,         // System clock.
  input  wire logic                   rst_i,           // Sync reset, high.
  input  wire logic [`ACS_ADDR_W-1:0] addr_i,          // Register address.
  input  wire logic [`ACS_DATA_W-1:0] wdata_i,         // Write data.
  input  wire logic                   we_i,            // Write strobe.
  input  wire logic                   re_i,            // Read strobe.
  output logic      [`ACS_DATA_W-1:0] rdata_o,         // Read data, +1 cycle.
  input  wire logic                   ccu5_trigger_i,  // Unit five event.
  input  wire logic                   ctu_trigger_i,   // Charge unit event.
  input  wire logic                   rc_tick_i,       // RC clock enable.
  input  wire logic                   sleep_i,         // Device asleep.
  input  wire logic                   comp_i,          // Comparator result.
  output logic                        afe_power_o,     // Converter powered.
  output logic                        sample_connect_o,// Channel to hold cap.
  output logic                        discharge_o,     // Discharge array.
  output logic      [CH_W-1:0]        channel_o,       // Selected channel.
  output logic      [RES_W-1:0]       sar_code_o,      // Trial code.
  output logic                        irq_o,           // Interrupt level.
  output logic                        wake_o           // Wake-up pulse.
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations.

  acs_state_t       state;
  logic [3:0]       count;
  logic             go;
  logic             module_on;
  logic [CH_W-1:0]  chan;
  logic             trig_sel;
  logic [2:0]       ccs;
  logic [2:0]       acq_sel;
  logic [RES_W-1:0] result;
  logic [RES_W-1:0] trial;
  logic [RES_W-1:0] bitm;
  logic [2:0]       status;
  logic [2:0]       mask;
  logic             module_disable;
  logic             conv_off;
  logic             sleep_q;
  logic             core_rst;
  logic             active;
  logic             use_rc;
  logic             run_tad;
  logic             tad;
  logic             wr_ctrl0;
  logic             wr_ctrl1;
  logic             wr_ctrl2;
  logic             wr_status;
  logic             wr_mask;
  logic             wr_pmd;
  logic             trig;
  logic             start_sw;
  logic             start_trg;
  logic             start;
  logic             miss;
  logic             sleep_rise;
  logic             sleep_off;
  logic             abort_any;
  logic             done_fire;
  logic [RES_W-1:0] next_result;
  logic [3:0]       acq_tads;
  logic [2:0]       next_status;
  logic [`ACS_DATA_W-1:0] rd_value;

  ////////////////////////////////////////////////////////////////////////////
  // Reset, enables and decode.

  // Module disable keeps every converter register in reset.
  assign core_rst  = rst_i || module_disable; // R3 R16
  assign active    = module_on && !conv_off && !module_disable; // R15 R16
  assign use_rc    = (ccs == `ACS_RC_CODE);

  assign wr_ctrl0  = we_i && !module_disable && (addr_i == `ACS_OFF_CTRL0);
  assign wr_ctrl1  = we_i && !module_disable && (addr_i == `ACS_OFF_CTRL1);
  assign wr_ctrl2  = we_i && !module_disable && (addr_i == `ACS_OFF_CTRL2);
  assign wr_status = we_i && !module_disable && (addr_i == `ACS_OFF_STATUS);
  assign wr_mask   = we_i && !module_disable && (addr_i == `ACS_OFF_MASK);
  assign wr_pmd    = we_i && (addr_i == `ACS_OFF_PMD);

  assign acq_tads  = 4'(int'(acq_sel) * `ACS_ACQ_TADS_PER);

  ////////////////////////////////////////////////////////////////////////////
  // Start, abort and completion events.

  assign trig = (trig_sel == `ACS_TRIG_CCU5) ? ccu5_trigger_i
                                             : ctu_trigger_i; // R11
  assign start_sw  = wr_ctrl0 && wdata_i[`ACS_GO_BIT] && active &&
                     (state == ST_IDLE);
  assign start_trg = trig && active && (state == ST_IDLE) && !start_sw; // R14
  assign start     = start_sw || start_trg;
  // A trigger while off or busy is dropped but leaves a trace for software.
  assign miss      = trig && !start_trg && !start_sw; // R15

  assign sleep_rise = sleep_i && !sleep_q;
  assign sleep_off  = sleep_rise && !use_rc && module_on; // R10

  assign abort_any = go && ((wr_ctrl0 && !wdata_i[`ACS_GO_BIT]) ||
                            (wr_ctrl0 && !wdata_i[`ACS_ON_BIT]) ||
                            sleep_off); // R2 R10

  assign done_fire = (state == ST_CONV) && tad && bitm[0] && !abort_any;

  assign next_result = comp_i ? trial : (trial & ~bitm);

  ////////////////////////////////////////////////////////////////////////////
  // Bit period generator.

  assign run_tad = ((state == ST_ACQ) || (state == ST_CONV) ||
                    (state == ST_WAIT)) && !abort_any; // R4

  acs_tad_gen #(
    .DIV_W (8)
  ) u_tad (
    .clock_i   (clock_i),
    .rst_i     (core_rst),
    .run_i     (run_tad),
    .sel_i     (ccs),
    .rc_tick_i (rc_tick_i),
    .tad_o     (tad)
  ); // R18

  ////////////////////////////////////////////////////////////////////////////
  // Sequence state.

  always_ff @(posedge clock_i) begin
    if (core_rst) begin
      state <= ST_IDLE; // R3
      count <= 4'h0;
    end else if (abort_any) begin
      state <= ST_WAIT; // R2 R4
      count <= use_rc ? '1 : 4'h0; // RC phase is free, so add a tick.
    end else begin
      case (state)
        ST_IDLE: begin
          count <= 4'h0;
          if (start) begin
            if (acq_tads != 4'h0) begin
              state <= ST_ACQ; // R14
            end else if (use_rc) begin
              state <= ST_RCDLY; // R7
            end else begin
              state <= ST_CONV;
            end
          end
        end
        ST_ACQ: begin
          if (tad) begin
            if (count == acq_tads - 4'h1) begin
              count <= 4'h0;
              state <= use_rc ? ST_RCDLY : ST_CONV; // R7
            end else begin
              count <= count + 4'h1;
            end
          end
        end
        ST_RCDLY: begin
          // One instruction cycle lets the core enter sleep first.
          if (count == 4'({1'b0, `ACS_INSTR_CYCLES}) - 4'h1) begin
            count <= 4'h0;
            state <= ST_CONV; // R7
          end else begin
            count <= count + 4'h1;
          end
        end
        ST_CONV: begin
          if (done_fire) begin
            count <= 4'h0;
            state <= ST_WAIT; // R4
          end
        end
        ST_WAIT: begin
          if (tad) begin
            if (count == `ACS_WAIT_TADS - 4'h1) begin
              count <= 4'h0;
              state <= ST_IDLE; // R4 R5
            end else begin
              count <= count + 4'h1;
            end
          end
        end
        default: begin
          state <= ST_IDLE;
          count <= 4'h0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Successive approximation.

  // Trial and bit pointer rest at the top bit outside a conversion.
  always_ff @(posedge clock_i) begin
    if (core_rst || (state != ST_CONV)) begin
      trial <= RES_W'(1) << (RES_W - 1);
      bitm  <= RES_W'(1) << (RES_W - 1);
    end else if (tad) begin
      trial <= next_result | (bitm >> 1);
      bitm  <= bitm >> 1;
    end
  end

  // A partial code never reaches the result.
  always_ff @(posedge clock_i) begin
    if (core_rst) begin
      result <= '0;
    end else if (done_fire) begin
      result <= next_result; // R1 R2
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control registers.

  always_ff @(posedge clock_i) begin
    if (core_rst) begin
      go <= 1'b0;
    end else if (done_fire || abort_any) begin
      go <= 1'b0; // R1 R2
    end else if (start) begin
      go <= 1'b1; // R14
    end
  end

  always_ff @(posedge clock_i) begin
    if (core_rst) begin
      module_on <= 1'b0;
      chan      <= '0;
    end else if (wr_ctrl0) begin
      module_on <= wdata_i[`ACS_ON_BIT];
      chan      <= wdata_i[`ACS_CHAN_MSB:`ACS_CHAN_LSB];
    end
  end

  always_ff @(posedge clock_i) begin
    if (core_rst) begin
      trig_sel <= 1'b0;
    end else if (wr_ctrl1) begin
      trig_sel <= wdata_i[`ACS_TRIG_BIT];
    end
  end

  // Changing the clock mid-conversion is the user's hazard, as advised.
  always_ff @(posedge clock_i) begin
    if (core_rst) begin
      ccs     <= 3'h0;
      acq_sel <= 3'h0;
    end else if (wr_ctrl2) begin
      ccs     <= wdata_i[`ACS_CCS_MSB:`ACS_CCS_LSB];
      acq_sel <= wdata_i[`ACS_ACQ_MSB:`ACS_ACQ_LSB];
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      module_disable <= 1'b0;
    end else if (wr_pmd) begin
      module_disable <= wdata_i[`ACS_PMD_BIT]; // R16
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sleep handling.

  always_ff @(posedge clock_i) begin
    if (core_rst) begin
      sleep_q <= 1'b0;
    end else begin
      sleep_q <= sleep_i;
    end
  end

  // The converter stays off, with the on bit still set, until sleep ends.
  always_ff @(posedge clock_i) begin
    if (core_rst) begin
      conv_off <= 1'b0;
    end else if (sleep_off) begin
      conv_off <= 1'b1; // R10
    end else if (done_fire && sleep_i && !mask[`ACS_DONE_BIT]) begin
      conv_off <= 1'b1; // R9
    end else if (!sleep_i) begin
      conv_off <= 1'b0;
    end
  end

  always_ff @(posedge clock_i) begin
    if (core_rst) begin
      wake_o <= 1'b0;
    end else begin
      wake_o <= done_fire && sleep_i && use_rc &&
                mask[`ACS_DONE_BIT]; // R8
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status and mask.

  always_comb begin
    next_status = status;
    if (wr_status) begin
      next_status = status & ~wdata_i[2:0];
    end
    // Setting after the clear lets a same-cycle event win.
    if (done_fire) begin
      next_status[`ACS_DONE_BIT] = 1'b1; // R1
    end
    if (abort_any) begin
      next_status[`ACS_ABORT_BIT] = 1'b1;
    end
    if (miss) begin
      next_status[`ACS_MISS_BIT] = 1'b1;
    end
  end

  always_ff @(posedge clock_i) begin
    if (core_rst) begin
      status <= 3'h0;
    end else begin
      status <= next_status;
    end
  end

  always_ff @(posedge clock_i) begin
    if (core_rst) begin
      mask <= 3'h0;
    end else if (wr_mask) begin
      mask <= wdata_i[2:0];
    end
  end

  assign irq_o = |(status & mask);

  ////////////////////////////////////////////////////////////////////////////
  // Register read.

  always_comb begin
    case (addr_i)
      `ACS_OFF_CTRL0:  rd_value = 8'({chan, module_on, go});
      `ACS_OFF_CTRL1:  rd_value = 8'({trig_sel});
      `ACS_OFF_CTRL2:  rd_value = 8'({acq_sel, ccs});
      `ACS_OFF_RESH:   rd_value = 8'(result >> 8);
      `ACS_OFF_RESL:   rd_value = result[7:0];
      `ACS_OFF_STATUS: rd_value = 8'(status);
      `ACS_OFF_MASK:   rd_value = 8'(mask);
      `ACS_OFF_PMD:    rd_value = 8'({module_disable});
      default:         rd_value = 8'h00;
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      rdata_o <= 8'h00;
    end else begin
      rdata_o <= re_i ? rd_value : 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Analog front end.

  assign afe_power_o      = active;
  assign sample_connect_o = active && ((state == ST_IDLE) ||
                                       (state == ST_ACQ)); // R5
  assign discharge_o      = (state == ST_WAIT); // R6
  assign channel_o        = chan;
  assign sar_code_o       = trial;

endmodule : acs_sequencer

// ### hw/acs_map.svh
// Register offsets, field positions and counts of the converter sequencer.
// Contract
// R1: Completion clears go, flags done, stores result.
// R2: Software go clear aborts, keeps previous result.
// R3: Device reset returns all converter state.
// R4: Wait two bit periods after completion or abort.
// R5: Reconnect selected channel after the wait.
// R6: Discharge capacitor array after every sample.
// R7: Internal RC clock adds one instruction cycle.
// R8: RC conversion done in sleep wakes if enabled.
// R9: Done in sleep, irq off: converter off.
// R10: Sleep without RC clock aborts, converter off.
// R11: Trigger select: zero unit five, one charge.
// R12: Software sets unit five mode to trigger.
// R13: Software sets charge unit trigger enable.
// R14: Enabled trigger sets go, starts acquisition.
// R15: Module off ignores triggers entirely; code still sets the miss status flag.
// R16: Module disable holds reset, stops clock.
// R17: Software picks RC clock below 1 MHz.
// R18: Bit period from clock select; waits counted so.
`ifndef ACS_MAP_SVH
`define ACS_MAP_SVH

`define ACS_ADDR_W          3
`define ACS_DATA_W          8

`define ACS_OFF_CTRL0       3'h0
`define ACS_OFF_CTRL1       3'h1
`define ACS_OFF_CTRL2       3'h2
`define ACS_OFF_RESH        3'h3
`define ACS_OFF_RESL        3'h4
`define ACS_OFF_STATUS      3'h5
`define ACS_OFF_MASK        3'h6
`define ACS_OFF_PMD         3'h7

`define ACS_GO_BIT          0
`define ACS_ON_BIT          1
`define ACS_CHAN_LSB        2
`define ACS_CHAN_MSB        6
`define ACS_TRIG_BIT        0
`define ACS_CCS_LSB         0
`define ACS_CCS_MSB         2
`define ACS_ACQ_LSB         3
`define ACS_ACQ_MSB         5
`define ACS_DONE_BIT        0
`define ACS_ABORT_BIT       1
`define ACS_MISS_BIT        2
`define ACS_PMD_BIT         0

`define ACS_RC_CODE         3'h7
`define ACS_TRIG_CCU5       1'h0
`define ACS_WAIT_TADS       4'h2
`define ACS_ACQ_TADS_PER    2
`define ACS_INSTR_CYCLES    3'h4

`endif

// ### hw/acs_pkg.sv
// Types shared by the converter sequencer files.
package acs_pkg;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_ACQ   = 3'h1,
    ST_RCDLY = 3'h3,
    ST_CONV  = 3'h2,
    ST_WAIT  = 3'h6
  } acs_state_t;

endpackage : acs_pkg

// ### hw/acs_tad_gen.sv
// Conversion bit period tick generator.
`timescale 1ns/1ps
`include "acs_map.svh"

module acs_tad_gen #(
  parameter int DIV_W = 8
) (
  input  wire logic       clock_i,    // System clock.
  input  wire logic       rst_i,      // Synchronous reset, active high.
  input  wire logic       run_i,      // High while periods are counted.
  input  wire logic [2:0] sel_i,      // Conversion clock select code.
  input  wire logic       rc_tick_i,  // Internal RC clock enable pulse.
  output logic            tad_o       // One-cycle pulse per bit period.
);

  logic [DIV_W-1:0] count;
  logic [DIV_W-1:0] limit;
  logic             use_rc;

  // Divide codes give 2 to the power code+1 system clocks per period.
  assign limit  = DIV_W'((32'h1 << (int'(sel_i) + 1)) - 1);
  assign use_rc = (sel_i == `ACS_RC_CODE);

  // Dropping run restarts the divider phase, so a divided period never starts short.
  always_ff @(posedge clock_i) begin
    if (rst_i || !run_i || use_rc) begin
      count <= '0;
    end else if (count == limit) begin
      count <= '0;
    end else begin
      count <= count + DIV_W'(1);
    end
  end

  assign tad_o = run_i && (use_rc ? rc_tick_i : (count == limit)); // R18

endmodule : acs_tad_gen

// ### tb/acs_afe_model.sv
// Behavioural comparator of the converter front end.
`timescale 1ns/1ps

module acs_afe_model (
  input  wire logic       clock_i,  // System clock.
  input  wire logic       power_i,  // Front end powered.
  input  wire logic [9:0] code_i,   // Trial code from the sequencer.
  input  wire logic [9:0] vin_i,    // Level held on the capacitor.
  output logic            comp_o    // Comparator decision.
);
  logic toggle = 1'b0;

  always @(posedge clock_i) begin
    toggle <= !toggle;
  end

  // An unpowered comparator decides nothing, so its output wanders.
  assign comp_o = power_i ? (vin_i >= code_i) : toggle;
endmodule : acs_afe_model

// ### tb/acs_sequencer_chk.sv
// Concurrent checks on the converter sequencer ports.
`timescale 1ns/1ps

module acs_sequencer_chk #(
  parameter int RES_W = 10
) (
  input wire logic             clock_i,          // System clock.
  input wire logic             rst_i,            // Sync reset, high.
  input wire logic             sleep_i,          // Device asleep.
  input wire logic             afe_power_o,      // Converter powered.
  input wire logic             sample_connect_o, // Channel to hold cap.
  input wire logic             discharge_o,      // Discharge array.
  input wire logic [RES_W-1:0] sar_code_o,       // Trial code.
  input wire logic             irq_o,            // Interrupt level.
  input wire logic             wake_o            // Wake-up pulse.
);
  localparam logic [RES_W-1:0] sar_mid = {1'b1, {(RES_W-1){1'b0}}};

  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (rst_i);

  AST_RESET_STATE: assert property ($fell(rst_i) |->
    sar_code_o == sar_mid && !afe_power_o && !discharge_o && !irq_o && !wake_o)
    else $error("outputs not at reset values");
  AST_WAIT_MIN: assert property ($rose(discharge_o) |-> discharge_o[*4])
    else $error("post-conversion wait too short");
  AST_RECONNECT: assert property ($fell(discharge_o) && afe_power_o
    |-> sample_connect_o) else $error("channel not reconnected");
  AST_DISCH_APART: assert property (discharge_o |-> !sample_connect_o)
    else $error("channel connected during discharge");
  AST_SAR_INIT: assert property ($rose(discharge_o) |=>
    sar_code_o == sar_mid) else $error("array not reinitialised");
  AST_POWER_GATE: assert property (!afe_power_o |-> !sample_connect_o)
    else $error("channel connected while converter off");
  AST_WAKE_PULSE: assert property (wake_o |-> $past(sleep_i) ##1 !wake_o)
    else $error("wake pulse malformed");
  AST_WAKE_IRQ: assert property (wake_o |=> irq_o)
    else $error("wake without pending interrupt");
endmodule : acs_sequencer_chk

bind acs_sequencer acs_sequencer_chk #(.RES_W(RES_W)) i_chk (
  .clock_i(clock_i), .rst_i(rst_i), .sleep_i(sleep_i),
  .afe_power_o(afe_power_o), .sample_connect_o(sample_connect_o),
  .discharge_o(discharge_o), .sar_code_o(sar_code_o), .irq_o(irq_o),
  .wake_o(wake_o)
);

// ### tb/tb.sv
// Self-checking bench of the converter sequencer.
`timescale 1ns/1ps

module tb;
  logic       clock_i = 1'b0;
  logic       rst_i = 1'b1;
  logic [2:0] addr_i = 3'h0;
  logic [7:0] wdata_i = 8'h00;
  logic       we_i = 1'b0;
  logic       re_i = 1'b0;
  logic       ccu5_trigger_i = 1'b0;
  logic       ctu_trigger_i = 1'b0;
  logic       rc_tick_i = 1'b0;
  logic       sleep_i = 1'b0;
  logic [9:0] vin = 10'h000;
  logic [3:0] rc_cnt = 4'h0;
  logic [7:0] rdata_o;
  logic [4:0] channel_o;
  logic [9:0] sar_code_o;
  logic       comp_i, afe_power_o, sample_connect_o;
  logic       discharge_o, irq_o, wake_o;
  int         errors = 0;
  int         n_tests = 0;

  always #5 clock_i = !clock_i;

  // The RC clock runs slow against the system clock, one tick in sixteen.
  always @(posedge clock_i) begin
    rc_cnt <= rc_cnt + 4'h1;
    rc_tick_i <= (rc_cnt == 4'hF);
  end

  acs_sequencer i_dut (
    .clock_i(clock_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .we_i(we_i), .re_i(re_i), .rdata_o(rdata_o),
    .ccu5_trigger_i(ccu5_trigger_i), .ctu_trigger_i(ctu_trigger_i),
    .rc_tick_i(rc_tick_i), .sleep_i(sleep_i), .comp_i(comp_i),
    .afe_power_o(afe_power_o), .sample_connect_o(sample_connect_o),
    .discharge_o(discharge_o), .channel_o(channel_o),
    .sar_code_o(sar_code_o), .irq_o(irq_o), .wake_o(wake_o));

  acs_afe_model i_afe (.clock_i(clock_i), .power_i(afe_power_o),
    .code_i(sar_code_o), .vin_i(vin), .comp_o(comp_i));

  ////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : give_verdict

  task automatic check(input logic [9:0] seen, input logic [9:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clock_i);
    addr_i <= a;
    wdata_i <= d;
    we_i <= 1'b1;
    @(posedge clock_i);
    we_i <= 1'b0;
  endtask : wr

  task automatic rd(input logic [2:0] a, output logic [9:0] d);
    @(posedge clock_i);
    addr_i <= a;
    re_i <= 1'b1;
    @(posedge clock_i);
    re_i <= 1'b0;
    @(negedge clock_i);
    d = {2'h0, rdata_o};
  endtask : rd

  task automatic pulse(input logic unit5);
    @(posedge clock_i);
    ccu5_trigger_i <= unit5;
    ctu_trigger_i <= !unit5;
    @(posedge clock_i);
    ccu5_trigger_i <= 1'b0;
    ctu_trigger_i <= 1'b0;
  endtask : pulse

  // Kind 0 waits for discharge, 1 for wake, 2 for the converter going off.
  task automatic wait_for(input int k);
    for (int i = 0; i < 3000; i++) begin
      @(negedge clock_i);
      if ((k == 0 && discharge_o === 1'b1) || (k == 1 && wake_o === 1'b1)
          || (k == 2 && afe_power_o === 1'b0)) return;
    end
    errors++;
    $display("MISMATCH at %0t: wait of kind %0d ran out", $time, k);
    give_verdict();
  endtask : wait_for

  task automatic finish_conv();
    int n;
    wait_for(0);
    n = 0;
    while (discharge_o === 1'b1 && n < 99) begin
      @(negedge clock_i);
      n++;
    end
    check(10'(n), 10'h004);
    check(10'(sample_connect_o), 10'h001);
  endtask : finish_conv

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [9:0] d;
    repeat (4) @(posedge clock_i);
    rst_i <= 1'b0;
    for (int k = 0; k < 8; k++) begin
      rd(3'(k), d);
      check(d, 10'h000);
    end
    wr(3'h6, 8'h01);
    wr(3'h0, 8'h0E);
    vin <= 10'h2A5;
    wr(3'h0, 8'h0F);
    finish_conv();
    check(10'(irq_o), 10'h001);
    rd(3'h3, d);
    check(d, 10'h002);
    rd(3'h4, d);
    check(d, 10'h0A5);
    rd(3'h0, d);
    check(d, 10'h00E);
    check(10'(channel_o), 10'h003);
    wr(3'h5, 8'h07);
    @(negedge clock_i);
    check(10'(irq_o), 10'h000);
    vin <= 10'h055;
    wr(3'h0, 8'h0F);
    repeat (6) @(posedge clock_i);
    wr(3'h0, 8'h0E);
    finish_conv();
    rd(3'h4, d);
    check(d, 10'h0A5);
    rd(3'h5, d);
    check(d, 10'h002);
    wr(3'h5, 8'h07);
    for (int k = 0; k < 2; k++) begin
      wr(3'h1, 8'(k));
      vin <= 10'h100 + 10'(k);
      pulse(k == 1);
      rd(3'h0, d);
      check(d, 10'h00E);
      pulse(k == 0);
      finish_conv();
      rd(3'h4, d);
      check(d, 10'(k));
      wr(3'h5, 8'h07);
    end
    wr(3'h2, 8'h08);
    wr(3'h0, 8'h0F);
    repeat (3) begin
      @(negedge clock_i);
      check(10'(sample_connect_o), 10'h001);
    end
    finish_conv();
    rd(3'h4, d);
    check(d, 10'h001);
    wr(3'h5, 8'h07);
    wr(3'h2, 8'h00);
    wr(3'h0, 8'h0C);
    pulse(1'b0);
    repeat (40) @(posedge clock_i);
    rd(3'h0, d);
    check(d, 10'h00C);
    rd(3'h5, d);
    check(d, 10'h004);
    wr(3'h5, 8'h07);
    wr(3'h0, 8'h0E);
    wr(3'h0, 8'h0F);
    repeat (4) @(posedge clock_i);
    sleep_i <= 1'b1;
    repeat (3) @(negedge clock_i);
    check(10'(afe_power_o), 10'h000);
    rd(3'h0, d);
    check(d, 10'h00E);
    rd(3'h5, d);
    check(d, 10'h002);
    @(posedge clock_i);
    sleep_i <= 1'b0;
    wr(3'h5, 8'h07);
    wr(3'h2, 8'h07);
    wr(3'h0, 8'h0F);
    sleep_i <= 1'b1;
    wait_for(1);
    check(10'(irq_o), 10'h001);
    @(posedge clock_i);
    sleep_i <= 1'b0;
    repeat (60) @(posedge clock_i);
    wr(3'h5, 8'h07);
    wr(3'h6, 8'h00);
    wr(3'h0, 8'h0F);
    sleep_i <= 1'b1;
    wait_for(2);
    rd(3'h0, d);
    check(d, 10'h00E);
    check(10'(irq_o), 10'h000);
    @(posedge clock_i);
    sleep_i <= 1'b0;
    repeat (60) @(posedge clock_i);
    wr(3'h7, 8'h01);
    @(negedge clock_i);
    check(10'(afe_power_o), 10'h000);
    wr(3'h0, 8'h0F);
    rd(3'h0, d);
    check(d, 10'h000);
    rd(3'h7, d);
    check(d, 10'h001);
    wr(3'h7, 8'h00);
    rd(3'h2, d);
    check(d, 10'h000);
    give_verdict();
  end
endmodule : tb
